// ==== rtl/dcc_dma_channel_control.sv ====
// Chosen here: the AHB-Lite register port and the register offsets.
module dcc_dma_channel_control (
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [dcc_pkg::NCH-1:0] trig_in,
	input wire logic [dcc_pkg::NCH-1:0] periph_req,
	output logic xfer_valid,
	input wire logic xfer_ready,
	output logic [dcc_pkg::CH_W-1:0] xfer_chan,
	output logic [31:0] xfer_src,
	output logic [31:0] xfer_dst,
	output logic [1:0] xfer_size,
	output logic [dcc_pkg::NCH-1:0] chan_active,
	output logic irq_flag_first,
	output logic irq_flag_second
);
	import dcc_pkg::*;

	logic clk_on, next_clk_on, ctl_en, next_ctl_en;
	logic [31:0] desc_base, next_desc_base;
	logic [NCH-1:0] flag_a, next_flag_a, flag_b, next_flag_b;
	logic [NCH-1:0] active, next_active, trig_q, next_trig_q;
	logic [NCH-1:0] int_a, next_int_a, int_b, next_int_b;
	logic [31:0] cfg [NCH];
	logic [31:0] next_cfg [NCH];
	logic [31:0] src_addr [NCH];
	logic [31:0] next_src_addr [NCH];
	logic [31:0] dst_addr [NCH];
	logic [31:0] next_dst_addr [NCH];
	logic [31:0] bsrc [NCH];
	logic [31:0] next_bsrc [NCH];
	logic [31:0] bdst [NCH];
	logic [31:0] next_bdst [NCH];
	logic [CNT_W-1:0] remain [NCH];
	logic [CNT_W-1:0] next_remain [NCH];
	logic [1:0] wcode [NCH];
	logic [1:0] next_wcode [NCH];
	dcc_xtype_t xtype [NCH];
	dcc_xtype_t next_xtype [NCH];
	logic [BURST_W-1:0] burst_left [NCH];
	logic [BURST_W-1:0] next_burst_left [NCH];
	logic [BURST_W-1:0] burst_len [NCH];
	logic xfer_pend, next_xfer_pend;
	logic [CH_W-1:0] next_xfer_chan;
	logic [31:0] next_xfer_src, next_xfer_dst, next_hrdata;
	logic [1:0] next_xfer_size;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr, wofs;
	logic [CH_W-1:0] wch;
	logic [NCH-1:0] trig_ev, eligible;

	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign xfer_valid = xfer_pend & clk_on;
	assign chan_active = active;
	assign irq_flag_first = |flag_a;
	assign irq_flag_second = |flag_b;
	assign wofs = wr_addr - CH_BASE;
	assign wch = wofs[CH_SHIFT+:CH_W];

	function automatic logic [31:0] rd_val(input logic [7:0] a);
		logic [7:0] ofs;
		logic [CH_W-1:0] ch;
		rd_val = RSV_READ;
		ofs = a - CH_BASE;
		ch = ofs[CH_SHIFT+:CH_W];
		if (a < CH_BASE)
		begin
			case (a)
				CTRL_OFS:
				begin
					rd_val[CTRL_CLK] = clk_on;
					rd_val[CTRL_EN] = ctl_en;
				end
				BASE_OFS: rd_val = desc_base;
				FLAGA_OFS: rd_val[NCH-1:0] = flag_a;
				FLAGB_OFS: rd_val[NCH-1:0] = flag_b;
				ACTIVE_OFS: rd_val[NCH-1:0] = active;
				default: rd_val = RSV_READ;
			endcase
		end
		else if (ofs < CH_SPAN)
		begin
			case (ofs[CH_SHIFT-1:0])
				CFG_OFS: rd_val = cfg[ch];
				XFER_OFS:
				begin
					rd_val[XF_CNT+:CNT_W] = remain[ch];
					rd_val[XF_WID+:2] = wcode[ch];
					rd_val[XF_TYPE+:2] = xtype[ch];
					rd_val[XF_INTA] = int_a[ch];
					rd_val[XF_INTB] = int_b[ch];
				end
				SRC_OFS: rd_val = src_addr[ch];
				DST_OFS: rd_val = dst_addr[ch];
				STAT_OFS:
				begin
					rd_val[STAT_ACT] = active[ch];
					rd_val[STAT_REM+:CNT_W+2] = {2'h0, remain[ch]} << wcode[ch];
				end
				default: rd_val = RSV_READ;
			endcase
		end
	endfunction

	// trigger qualification per channel
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			logic pol_hi, now_act, was_act, is_lvl;
			dcc_trig_t t;
			dcc_burst_t bm;
			logic [3:0] p;
			t = dcc_trig_t'(cfg[c][CFG_TRIG+:3]);
			bm = dcc_burst_t'(cfg[c][CFG_BURST+:2]);
			p = cfg[c][CFG_POW+:4];
			pol_hi = (t == TRIG_HIGH) || (t == TRIG_RISE);
			is_lvl = (t == TRIG_LOW) || (t == TRIG_HIGH);
			now_act = (trig_in[c] == pol_hi) && (t != TRIG_NONE);
			was_act = (trig_q[c] == pol_hi) && (t != TRIG_NONE);
			// level trigger in single mode counts as one event per assertion
			trig_ev[c] = now_act && !was_act && !(is_lvl && bm == BURST_LEVEL)
				&& cfg[c][CFG_EN] && active[c];
			if (p > POW_MAX)
				p = POW_MAX;
			if (bm == BURST_EDGE && !is_lvl)
				burst_len[c] = {{(BURST_W-1){1'b0}}, 1'b1} << p;
			else
				burst_len[c] = {{(BURST_W-1){1'b0}}, 1'b1};
			eligible[c] = active[c] && cfg[c][CFG_EN]
				&& (!cfg[c][CFG_PREQ] || periph_req[c])
				&& ((t == TRIG_NONE) || (is_lvl && bm == BURST_LEVEL && now_act)
				|| (burst_left[c] != '0));
		end
	end

	always_comb
	begin
		logic found;
		logic [CH_W-1:0] best, fc;
		logic [PRIO_W-1:0] best_p;
		logic [31:0] step;
		found = 1'b0;
		best = '0;
		best_p = '1;
		fc = xfer_chan;
		step = 32'h1 << wcode[xfer_chan];
		next_clk_on = clk_on;
		next_ctl_en = ctl_en;
		next_desc_base = desc_base;
		next_flag_a = flag_a;
		next_flag_b = flag_b;
		next_active = active;
		next_int_a = int_a;
		next_int_b = int_b;
		next_cfg = cfg;
		next_src_addr = src_addr;
		next_dst_addr = dst_addr;
		next_bsrc = bsrc;
		next_bdst = bdst;
		next_remain = remain;
		next_wcode = wcode;
		next_xtype = xtype;
		next_burst_left = burst_left;
		next_xfer_pend = xfer_pend;
		next_xfer_chan = xfer_chan;
		next_xfer_src = xfer_src;
		next_xfer_dst = xfer_dst;
		next_xfer_size = xfer_size;
		next_trig_q = trig_in;
		next_hrdata = hrdata;
		next_wr_pend = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
		next_wr_addr = haddr[7:0];
		if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite)
			next_hrdata = rd_val(haddr[7:0]);
		if (wr_pend)
		begin
			if (wr_addr < CH_BASE)
			begin
				case (wr_addr)
					CTRL_OFS:
					begin
						next_clk_on = hwdata[CTRL_CLK];
						next_ctl_en = hwdata[CTRL_EN];
					end
					BASE_OFS: next_desc_base = hwdata;
					FLAGA_OFS: next_flag_a = flag_a & ~hwdata[NCH-1:0];
					FLAGB_OFS: next_flag_b = flag_b & ~hwdata[NCH-1:0];
					default: next_desc_base = desc_base;
				endcase
			end
			else if (wofs < CH_SPAN)
			begin
				case (wofs[CH_SHIFT-1:0])
					CFG_OFS: next_cfg[wch] = hwdata & CFG_MASK;
					XFER_OFS:
						// a busy channel refuses a new descriptor
						if (!active[wch] && hwdata[XF_CNT+:CNT_W] != '0)
						begin
							next_remain[wch] = hwdata[XF_CNT+:CNT_W];
							next_wcode[wch] = hwdata[XF_WID+:2];
							next_xtype[wch] = dcc_xtype_t'(hwdata[XF_TYPE+:2]);
							next_int_a[wch] = hwdata[XF_INTA];
							next_int_b[wch] = hwdata[XF_INTB];
							next_active[wch] = 1'b1;
							next_burst_left[wch] = '0;
							next_bsrc[wch] = src_addr[wch];
							next_bdst[wch] = dst_addr[wch];
						end
					SRC_OFS:
						if (!active[wch])
							next_src_addr[wch] = hwdata;
					DST_OFS:
						if (!active[wch])
							next_dst_addr[wch] = hwdata;
					default: next_cfg[wch] = cfg[wch];
				endcase
			end
		end
		// a gated clock freezes transfers, trigger bursts and arbitration; register writes still apply
		if (clk_on)
		begin
			if (xfer_pend && xfer_ready)
			begin
				next_xfer_pend = 1'b0;
				if (xtype[fc] == XT_M2M || xtype[fc] == XT_M2P)
					next_src_addr[fc] = src_addr[fc] + step;
				if (xtype[fc] == XT_M2M || xtype[fc] == XT_P2M)
					next_dst_addr[fc] = dst_addr[fc] + step;
				if (burst_left[fc] != '0)
				begin
					next_burst_left[fc] = burst_left[fc] - 1'b1;
					if (burst_left[fc] == 1'b1 && cfg[fc][CFG_SWRAP])
						next_src_addr[fc] = bsrc[fc];
					if (burst_left[fc] == 1'b1 && cfg[fc][CFG_DWRAP])
						next_dst_addr[fc] = bdst[fc];
				end
				next_remain[fc] = remain[fc] - 1'b1;
				if (remain[fc] == 1'b1)
				begin
					next_active[fc] = 1'b0;
					next_burst_left[fc] = '0;
					// set wins over a same-cycle clear
					if (cfg[fc][CFG_IEN])
					begin
						next_flag_a[fc] = next_flag_a[fc] | int_a[fc];
						next_flag_b[fc] = next_flag_b[fc] | int_b[fc];
					end
				end
			end
			for (int c = 0; c < NCH; c++)
				if (trig_ev[c])
				begin
					next_burst_left[c] = burst_len[c];
					next_bsrc[c] = next_src_addr[c];
					next_bdst[c] = next_dst_addr[c];
				end
			if (!xfer_pend && ctl_en)
			begin
				for (int c = 0; c < NCH; c++)
					if (eligible[c] && (!found || cfg[c][CFG_PRIO+:PRIO_W] < best_p))
					begin
						found = 1'b1;
						best = CH_W'(c);
						best_p = cfg[c][CFG_PRIO+:PRIO_W];
					end
				if (found)
				begin
					next_xfer_pend = 1'b1;
					next_xfer_chan = best;
					next_xfer_src = src_addr[best];
					next_xfer_dst = dst_addr[best];
					next_xfer_size = wcode[best];
				end
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			clk_on <= 1'b0;
			ctl_en <= 1'b0;
			desc_base <= '0;
			flag_a <= '0;
			flag_b <= '0;
			active <= '0;
			int_a <= '0;
			int_b <= '0;
			trig_q <= '0;
			for (int c = 0; c < NCH; c++)
			begin
				cfg[c] <= '0;
				src_addr[c] <= '0;
				dst_addr[c] <= '0;
				bsrc[c] <= '0;
				bdst[c] <= '0;
				remain[c] <= '0;
				wcode[c] <= '0;
				xtype[c] <= XT_M2M;
				burst_left[c] <= '0;
			end
			xfer_pend <= 1'b0;
			xfer_chan <= '0;
			xfer_src <= '0;
			xfer_dst <= '0;
			xfer_size <= '0;
			hrdata <= '0;
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end
		else
		begin
			clk_on <= next_clk_on;
			ctl_en <= next_ctl_en;
			desc_base <= next_desc_base;
			flag_a <= next_flag_a;
			flag_b <= next_flag_b;
			active <= next_active;
			int_a <= next_int_a;
			int_b <= next_int_b;
			trig_q <= next_trig_q;
			cfg <= next_cfg;
			src_addr <= next_src_addr;
			dst_addr <= next_dst_addr;
			bsrc <= next_bsrc;
			bdst <= next_bdst;
			remain <= next_remain;
			wcode <= next_wcode;
			xtype <= next_xtype;
			burst_left <= next_burst_left;
			xfer_pend <= next_xfer_pend;
			xfer_chan <= next_xfer_chan;
			xfer_src <= next_xfer_src;
			xfer_dst <= next_xfer_dst;
			xfer_size <= next_xfer_size;
			hrdata <= next_hrdata;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
		end
	end
endmodule

// ==== common/dcc_pkg.sv ====
package dcc_pkg;
	localparam int NCH = 4;
	localparam int CH_W = 2;
	localparam int CNT_W = 16;
	localparam int BURST_W = 11;
	localparam int PRIO_W = 3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] BASE_OFS = 8'h04;
	localparam logic [7:0] FLAGA_OFS = 8'h08;
	localparam logic [7:0] FLAGB_OFS = 8'h0C;
	localparam logic [7:0] ACTIVE_OFS = 8'h10;
	localparam logic [7:0] CH_BASE = 8'h40;
	localparam logic [7:0] CH_SPAN = 8'h80;
	localparam int CH_SHIFT = 5;
	localparam logic [4:0] CFG_OFS = 5'h00;
	localparam logic [4:0] XFER_OFS = 5'h04;
	localparam logic [4:0] SRC_OFS = 5'h08;
	localparam logic [4:0] DST_OFS = 5'h0C;
	localparam logic [4:0] STAT_OFS = 5'h10;
	localparam int CTRL_CLK = 0;
	localparam int CTRL_EN = 1;
	localparam int CFG_EN = 0;
	localparam int CFG_PREQ = 1;
	localparam int CFG_IEN = 2;
	localparam int CFG_TRIG = 3;
	localparam int CFG_BURST = 6;
	localparam int CFG_POW = 8;
	localparam int CFG_SWRAP = 12;
	localparam int CFG_DWRAP = 13;
	localparam int CFG_PRIO = 16;
	localparam logic [31:0] CFG_MASK = 32'h0007_3FFF;
	localparam int XF_CNT = 0;
	localparam int XF_WID = 16;
	localparam int XF_TYPE = 18;
	localparam int XF_INTA = 20;
	localparam int XF_INTB = 21;
	localparam int STAT_ACT = 0;
	localparam int STAT_REM = 8;
	localparam logic [3:0] POW_MAX = 4'hA;
	localparam logic [31:0] RSV_READ = 32'h0;
	typedef enum logic [2:0] {TRIG_NONE, TRIG_LOW, TRIG_HIGH, TRIG_FALL, TRIG_RISE} dcc_trig_t;
	typedef enum logic [1:0] {BURST_SINGLE, BURST_LEVEL, BURST_EDGE, BURST_RSVD} dcc_burst_t;
	typedef enum logic [1:0] {XT_M2M, XT_P2M, XT_M2P, XT_FIXED} dcc_xtype_t;
endpackage

// ==== testbench/dcc_chk.sv ====
module dcc_chk (
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic xfer_valid,
	input wire logic xfer_ready,
	input wire logic [dcc_pkg::CH_W-1:0] xfer_chan,
	input wire logic [31:0] xfer_src,
	input wire logic [31:0] xfer_dst,
	input wire logic [dcc_pkg::NCH-1:0] chan_active,
	input wire logic irq_flag_first,
	input wire logic irq_flag_second
);
	timeunit 1ns;
	timeprecision 1ps;
	import dcc_pkg::*;
	logic wr_take;
	logic acc;
	assign wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
	assign acc = xfer_valid && xfer_ready;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	sequence s_stall;
		xfer_valid && !xfer_ready;
	endsequence
	sequence s_drop;
		($past(chan_active) & ~chan_active) != '0;
	endsequence
	property p_hold;
		s_stall |=> xfer_valid && $stable(xfer_chan) && $stable(xfer_src) && $stable(xfer_dst);
	endproperty
	property p_gap;
		acc |=> !xfer_valid;
	endproperty
	property p_own;
		xfer_valid |-> chan_active[xfer_chan];
	endproperty
	property p_quiet;
		chan_active == '0 |-> !xfer_valid;
	endproperty
	// a channel only wakes from a register write two edges earlier
	property p_start;
		(chan_active & ~$past(chan_active)) != '0 |-> $past(wr_take, 2);
	endproperty
	property p_end;
		s_drop |-> $past(acc);
	endproperty
	property p_irqa;
		$rose(irq_flag_first) |-> $past(acc) ##0 s_drop;
	endproperty
	property p_irqb;
		$rose(irq_flag_second) |-> $past(acc) ##0 s_drop;
	endproperty
	a_hold: assert property (p_hold) else $error("request changed while stalled");
	a_gap: assert property (p_gap) else $error("request right after accept");
	a_own: assert property (p_own) else $error("request from idle channel");
	a_quiet: assert property (p_quiet) else $error("request with no channel active");
	a_start: assert property (p_start) else $error("channel woke without write");
	a_end: assert property (p_end) else $error("channel ended without accept");
	a_irqa: assert property (p_irqa) else $error("first flag not at completion");
	a_irqb: assert property (p_irqb) else $error("second flag not at completion");
endmodule

bind dcc_dma_channel_control dcc_chk u_chk (.clock, .rstn, .hsel, .htrans, .hwrite,
	.hready, .xfer_valid, .xfer_ready, .xfer_chan, .xfer_src, .xfer_dst, .chan_active,
	.irq_flag_first, .irq_flag_second);

// ==== testbench/dcc_mem_model.sv ====
module dcc_mem_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic slow,
	input wire logic xfer_valid,
	input wire logic [dcc_pkg::CH_W-1:0] xfer_chan,
	input wire logic [31:0] xfer_src,
	input wire logic [31:0] xfer_dst,
	input wire logic [1:0] xfer_size,
	output logic xfer_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import dcc_pkg::*;
	logic [1:0] wait_cnt;
	logic [CH_W-1:0] log_ch[$];
	logic [31:0] log_src[$];
	logic [31:0] log_dst[$];
	logic [1:0] log_size[$];
	// slow mode stalls two cycles per element to exercise holding
	assign xfer_ready = xfer_valid && (!slow || wait_cnt == 2'h2);
	always_ff @(posedge clock)
	begin
		if (!rstn || !xfer_valid || xfer_ready)
			wait_cnt <= 2'h0;
		else
			wait_cnt <= wait_cnt + 2'h1;
		if (rstn && xfer_valid && xfer_ready)
		begin
			log_ch.push_back(xfer_chan);
			log_src.push_back(xfer_src);
			log_dst.push_back(xfer_dst);
			log_size.push_back(xfer_size);
		end
	end
endmodule

// ==== testbench/dcc_dma_channel_control_tb.sv ====
module dcc_dma_channel_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dcc_pkg::*;
	logic clock, rstn, hsel, hwrite, hready, hreadyout, hresp, slow, xfer_valid, xfer_ready;
	logic irq_flag_first, irq_flag_second;
	logic [31:0] haddr, hwdata, hrdata, xfer_src, xfer_dst, rdat;
	logic [1:0] htrans, xfer_size, xfer_chan;
	logic [2:0] hsize;
	logic [3:0] trig_in, periph_req, chan_active;
	int fails = 0;
	int total_checks = 0;
	assign hready = hreadyout;
	dcc_dma_channel_control dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .trig_in, .periph_req, .xfer_valid,
		.xfer_ready, .xfer_chan, .xfer_src, .xfer_dst, .xfer_size, .chan_active,
		.irq_flag_first, .irq_flag_second);
	dcc_mem_model mem (.clock, .rstn, .slow, .xfer_valid, .xfer_chan, .xfer_src, .xfer_dst,
		.xfer_size, .xfer_ready);
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rdat = hrdata;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, rdat);
		chk("resp", 32'(HRESP_OKAY), 32'(hresp));
	endtask
	function automatic logic [7:0] ca(input int c, input logic [4:0] o);
		return CH_BASE + 8'(c << CH_SHIFT) + 8'(o);
	endfunction
	function automatic logic [31:0] cfgv(input logic [2:0] t, input logic [1:0] b,
		input logic [3:0] p, input logic [2:0] pr, input logic ie);
		return 32'h1 | 32'(ie) << CFG_IEN | 32'(t) << CFG_TRIG | 32'(b) << CFG_BURST
			| 32'(p) << CFG_POW | 32'(pr) << CFG_PRIO;
	endfunction
	function automatic logic [31:0] xw(input int n, input int w, input int ty, input int ia,
		input int ib);
		return 32'(n) | 32'(w) << XF_WID | 32'(ty) << XF_TYPE | 32'(ia) << XF_INTA
			| 32'(ib) << XF_INTB;
	endfunction
	task automatic load(input int c, input logic [31:0] cf, s, d, x);
		bus(1'b1, ca(c, SRC_OFS), s);
		bus(1'b1, ca(c, DST_OFS), d);
		bus(1'b1, ca(c, CFG_OFS), cf);
		bus(1'b1, ca(c, XFER_OFS), x);
	endtask
	task automatic wait_idle(input int c);
		#1;
		for (int i = 0; i < 400 && chan_active[c] !== 1'b0; i++)
			@(posedge clock);
		// a channel still busy here means the wait ran out
		chk("idle", 32'h0, 32'(chan_active[c]));
	endtask
	task automatic pop(input int c, input logic [31:0] s, input logic [31:0] d, input int w);
		chk("chan", 32'(c), 32'(mem.log_ch.pop_front()));
		chk("src", s, mem.log_src.pop_front());
		chk("dst", d, mem.log_dst.pop_front());
		chk("size", 32'(w), 32'(mem.log_size.pop_front()));
	endtask
	task automatic t_gate;
		rc("ctrl", CTRL_OFS, 32'h0);
		rc("unmap", 8'h30, 32'h0);
		for (int t = 0; t < 5; t++)
		begin
			bus(1'b1, ca(3, CFG_OFS), 32'hFFFF_3002 | 32'(t) << CFG_TRIG);
			rc("cfg", ca(3, CFG_OFS), 32'h0007_3002 | 32'(t) << CFG_TRIG);
		end
		bus(1'b1, ca(3, CFG_OFS), 32'h0);
		rc("preq", ca(3, CFG_OFS), 32'h0);
		load(0, cfgv(TRIG_NONE, BURST_SINGLE, 0, 0, 1), 32'h100, 32'h200, xw(3, 1, 0, 1, 0));
		rc("stat", ca(0, STAT_OFS), 32'h601);
		repeat (10) @(posedge clock);
		chk("gated", 32'h0, 32'(mem.log_ch.size()));
		bus(1'b1, CTRL_OFS, 32'h1);
		bus(1'b1, BASE_OFS, 32'hA000);
		bus(1'b1, CTRL_OFS, 32'h3);
		rc("base", BASE_OFS, 32'hA000);
		wait_idle(0);
		for (int i = 0; i < 3; i++)
			pop(0, 32'h100 + 2 * i, 32'h200 + 2 * i, 1);
		rc("left", ca(0, STAT_OFS), 32'h0);
		chk("irqa", 32'h1, 32'(irq_flag_first));
		bus(1'b1, FLAGA_OFS, 32'h1);
		#1;
		chk("clra", 32'h0, 32'(irq_flag_first));
	endtask
	task automatic t_types;
		for (int t = 0; t < 4; t++)
		begin
			load(1, cfgv(TRIG_NONE, BURST_SINGLE, 0, 0, 1), 32'h1000, 32'h2000,
				xw(2, 2, t, t % 2 == 0, t % 2));
			wait_idle(1);
			for (int i = 0; i < 2; i++)
				pop(1, 32'h1000 + (t % 2 == 0 ? 4 * i : 0), 32'h2000 + (t < 2 ? 4 * i : 0),
					2);
			#1;
			chk("irqa", 32'(t % 2 == 0), 32'(irq_flag_first));
			chk("irqb", 32'(t % 2), 32'(irq_flag_second));
			bus(1'b1, FLAGA_OFS, 32'h2);
			bus(1'b1, FLAGB_OFS, 32'h2);
		end
	endtask
	task automatic t_prio;
		int pr[4] = '{5, 2, 2, 7};
		int ord[4] = '{1, 2, 0, 3};
		bus(1'b1, CTRL_OFS, 32'h0);
		slow <= 1'b1;
		for (int c = 0; c < 4; c++)
			load(c, cfgv(TRIG_NONE, BURST_SINGLE, 0, pr[c], 0), 32'h40 * c, 32'h80, xw(1, 2, 3, 0, 0));
		bus(1'b1, CTRL_OFS, 32'h3);
		for (int c = 0; c < 4; c++)
			wait_idle(c);
		foreach (ord[i])
			pop(ord[i], 32'h40 * ord[i], 32'h80, 2);
		slow <= 1'b0;
	endtask
	task automatic t_edge;
		load(2, cfgv(TRIG_RISE, BURST_EDGE, 2, 0, 0), 32'h300, 32'h400, xw(8, 0, 0, 0, 1));
		repeat (10) @(posedge clock);
		chk("idle", 32'h0, 32'(mem.log_ch.size()));
		trig_in <= 4'h4;
		repeat (40) @(posedge clock);
		trig_in <= 4'h0;
		repeat (40) @(posedge clock);
		chk("burst", 32'h4, 32'(mem.log_ch.size()));
		bus(1'b1, ca(2, XFER_OFS), xw(5, 0, 0, 0, 0));
		rc("half", ca(2, STAT_OFS), 32'h401);
		trig_in <= 4'h4;
		wait_idle(2);
		chk("all", 32'h8, 32'(mem.log_ch.size()));
		#1;
		chk("mask", 32'h0, 32'(irq_flag_second));
		trig_in <= 4'h0;
	endtask
	task automatic t_level;
		trig_in <= 4'h8;
		load(3, cfgv(TRIG_HIGH, BURST_LEVEL, 0, 0, 0) | 32'h1 << CFG_PREQ, 32'h700, 32'h800,
			xw(3, 2, 3, 0, 0));
		repeat (10) @(posedge clock);
		chk("preq", 32'h0, 32'(mem.log_ch.size()));
		periph_req <= 4'h8;
		wait_idle(3);
		for (int i = 0; i < 3; i++)
			pop(3, 32'h700, 32'h800, 2);
		trig_in <= 4'h0;
		periph_req <= 4'h0;
	endtask
	task automatic t_wrap;
		load(0, cfgv(TRIG_FALL, BURST_EDGE, 1, 0, 0) | 32'h1 << CFG_SWRAP, 32'h500, 32'h600,
			xw(4, 2, 0, 0, 0));
		repeat (10) @(posedge clock);
		chk("armed", 32'h0, 32'(mem.log_ch.size()));
		for (int k = 0; k < 2; k++)
		begin
			trig_in <= 4'h1;
			repeat (2) @(posedge clock);
			trig_in <= 4'h0;
			repeat (20) @(posedge clock);
			chk("pair", 32'(2 * k + 2), 32'(mem.log_ch.size()));
		end
		wait_idle(0);
		for (int i = 0; i < 4; i++)
			pop(0, 32'h500 + 4 * (i % 2), 32'h600 + 4 * i, 2);
	endtask
	initial
	begin
		#300us;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		rstn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		trig_in = 4'h0;
		periph_req = 4'h0;
		slow = 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_gate();
		t_types();
		t_prio();
		t_level();
		t_wrap();
		t_edge();
		tally_and_finish();
	end
endmodule
